// [core/sctc_core.sv]
// standby control, count source select, timer and test request flags
// How it works
// - cpu clock enable toggles each system cycle, halved system clock
// - external clock option gates the oscillator clock enable with the oscillator input pin
// - stop instruction sets stop flop, halting oscillator and all derived clocks
// - rc variant: any flag or reset fall clears stop flop
// - ceramic variant: reset high clears stop, clocks resume after reset low
// - halt instruction sets halt flop, blocking the cpu clock divider
// - any request flag or reset fall clears halt flop
// - halt flop held set while reset is high
// - two-bit select: 256, event pin, 32, 4 division
// - eight-bit up-counter counts each selected pulse
// - timer instruction or reset clears counter
// - counter wraps from maximum to zero
// - wrap sets timer flag; test-and-clear or timer instruction clears it
// - shared flag source: serial when select bit 0, pin when 1
// - serial mode: transfer done sets, test-and-clear or serial start clears
// - pin mode: rising edge sets, only test-and-clear or reset clears
// - test-and-clear reports flag state and clears tested flag
// - or of both flags releases stop or halt
// - reset clears flags and source select bit
// - standby entry refused while any flag is set
// - standby keeps state; timer runs while its clock runs
// - externally clocked rc variant treats stop as halt
`timescale 1ns/1ps
module sctc_core #(
  parameter bit RC_VARIANT = 1'b1,
  parameter bit EXT_CLOCK = 1'b0
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic clock_en_i,
  input wire logic reset_pin_i,
  input wire logic osc_input_pin_i,
  input wire logic stop_instr_i,
  input wire logic halt_instr_i,
  input wire logic timer_instr_i,
  input wire logic port_output_instruction_i,
  input wire logic [1:0] port_data_i,
  input wire logic test_and_clear_instruction_i,
  input wire logic test_select_i,
  input wire logic serial_start_instruction_i,
  input wire logic serial_done_event_i,
  input wire logic request_source_write_i,
  input wire logic request_source_data_i,
  input wire logic event_pin_i,
  output logic osc_clock_en_o,
  output logic cpu_clock_en_o,
  output logic stop_mode_o,
  output logic halt_mode_o,
  output logic [7:0] timer_count_o,
  output logic timer_overflow_request_o,
  output logic shared_request_flag_o,
  output logic test_result_o,
  output logic test_valid_o,
  output logic request_source_select_o
);
  logic reset_pin_ff;
  logic stop_ff;
  logic halt_ff;
  logic phase_ff;
  logic osc_en_ff;
  logic cpu_en_ff;
  logic [1:0] source_sel_ff;
  logic [7:0] count_ff;
  logic timer_flag_ff;
  logic shared_flag_ff;
  logic request_source_select_ff;
  logic event_meta_ff;
  logic event_sync_ff;
  logic event_prev_ff;
  logic test_result_ff;
  logic test_valid_ff;
  logic tick256;
  logic tick32;
  logic tick4;

  wire reset_fall = reset_pin_ff && !reset_pin_i;
  wire release_req = timer_flag_ff || shared_flag_ff;
  wire stop_blocks = RC_VARIANT && EXT_CLOCK;
  // the system clock runs unless the stop flop holds the oscillator
  wire sys_run = !stop_ff || stop_blocks;
  wire sys_ce = clock_en_i && sys_run;
  // ceramic parts keep clocks off until reset drops
  wire sys_tick = sys_ce && (RC_VARIANT || !reset_pin_i);
  wire event_rise = event_sync_ff && !event_prev_ff;
  wire tested_flag = test_select_i ? shared_flag_ff : timer_flag_ff;
  wire source_sel_low = source_sel_ff[0];
  wire source_sel_high = source_sel_ff[1];
  wire sel_event = {source_sel_high, source_sel_low} == sctc_pkg::SEL_EVENT;
  wire osc_clock = EXT_CLOCK ? osc_input_pin_i : 1'b1;
  logic count_pulse;
  always_comb begin
    unique case ({source_sel_high, source_sel_low})
      sctc_pkg::SEL_DIV256: count_pulse = tick256;
      sctc_pkg::SEL_EVENT: count_pulse = event_rise;
      sctc_pkg::SEL_DIV32: count_pulse = tick32;
      sctc_pkg::SEL_DIV4: count_pulse = tick4;
    endcase
  end
  // counting continues in halt; in stop only the event pin can advance it
  wire count_step = count_pulse && (sys_tick || ({source_sel_high, source_sel_low} == sctc_pkg::SEL_EVENT));
  wire wrap = count_step && (count_ff == sctc_pkg::TIMER_MAX);
  wire [7:0] nxt_count = timer_instr_i ? sctc_pkg::TIMER_RESET : (count_step ? count_ff + 8'h01 : count_ff);
  wire serial_set = !request_source_select_ff && serial_done_event_i;
  wire pin_set = request_source_select_ff && event_rise;
  wire shared_set = serial_set || pin_set;
  wire test_timer = test_and_clear_instruction_i && !test_select_i;
  wire test_shared = test_and_clear_instruction_i && test_select_i;
  wire shared_clear = test_shared || (serial_start_instruction_i && !request_source_select_ff);
  wire timer_clear = test_timer || timer_instr_i;
  // set beats clear in the same cycle so no event is lost
  wire nxt_timer_flag = wrap || (timer_flag_ff && !timer_clear);
  wire nxt_shared_flag = shared_set || (shared_flag_ff && !shared_clear);
  wire enter_ok = !release_req;
  wire nxt_stop = reset_pin_i ? 1'b0 : (release_req || reset_fall) ? 1'b0 : (stop_ff || (stop_instr_i && enter_ok));
  wire nxt_halt = reset_pin_i ? 1'b1 : (release_req || reset_fall) ? 1'b0 : (halt_ff || (halt_instr_i && enter_ok));

  sctc_prescaler u_div256 (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .run_i(sys_tick),
    .mask_i(sctc_pkg::MASK_DIV256), .tick_o(tick256));
  sctc_prescaler u_div32 (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .run_i(sys_tick),
    .mask_i(sctc_pkg::MASK_DIV32), .tick_o(tick32));
  sctc_prescaler u_div4 (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .run_i(sys_tick),
    .mask_i(sctc_pkg::MASK_DIV4), .tick_o(tick4));

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      reset_pin_ff <= 1'b0;
      stop_ff <= 1'b0;
      halt_ff <= 1'b0;
      phase_ff <= 1'b0;
      osc_en_ff <= 1'b0;
      cpu_en_ff <= 1'b0;
      event_meta_ff <= 1'b0;
      event_sync_ff <= 1'b0;
      event_prev_ff <= 1'b0;
    end else if (clock_en_i) begin
      reset_pin_ff <= reset_pin_i;
      stop_ff <= nxt_stop;
      halt_ff <= nxt_halt;
      osc_en_ff <= sys_tick && osc_clock;
      // halt gates the divider input, so the cpu phase freezes
      if (sys_tick && !halt_ff) begin
        phase_ff <= !phase_ff;
      end
      cpu_en_ff <= sys_tick && !halt_ff && !stop_ff && phase_ff;
      event_meta_ff <= event_pin_i;
      event_sync_ff <= event_meta_ff;
      event_prev_ff <= event_sync_ff;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      source_sel_ff <= sctc_pkg::SEL_RESET;
      count_ff <= sctc_pkg::TIMER_RESET;
      timer_flag_ff <= 1'b0;
      shared_flag_ff <= 1'b0;
      request_source_select_ff <= 1'b0;
      test_result_ff <= 1'b0;
      test_valid_ff <= 1'b0;
    end else if (clock_en_i) begin
      if (reset_pin_i) begin
        count_ff <= sctc_pkg::TIMER_RESET;
        timer_flag_ff <= 1'b0;
        shared_flag_ff <= 1'b0;
        request_source_select_ff <= 1'b0;
        test_valid_ff <= 1'b0;
      end else begin
        count_ff <= nxt_count;
        timer_flag_ff <= nxt_timer_flag;
        shared_flag_ff <= nxt_shared_flag;
        if (request_source_write_i) begin
          request_source_select_ff <= request_source_data_i;
        end
        if (port_output_instruction_i) begin
          source_sel_ff <= port_data_i;
        end
        test_valid_ff <= test_and_clear_instruction_i;
        if (test_and_clear_instruction_i) begin
          test_result_ff <= test_select_i ? shared_flag_ff : timer_flag_ff;
        end
      end
    end
  end

  assign osc_clock_en_o = osc_en_ff;
  assign cpu_clock_en_o = cpu_en_ff;
  assign stop_mode_o = stop_ff;
  assign halt_mode_o = halt_ff;
  assign timer_count_o = count_ff;
  assign timer_overflow_request_o = timer_flag_ff;
  assign shared_request_flag_o = shared_flag_ff;
  assign test_result_o = test_result_ff;
  assign test_valid_o = test_valid_ff;
  assign request_source_select_o = request_source_select_ff;

  property p_wrap_sets_flag;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && wrap) |=> timer_flag_ff;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap did not set timer flag");

  property p_wrap_zero;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && wrap && !timer_instr_i) |=> (count_ff == 8'h00);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap to zero");

  property p_reset_halts;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && reset_pin_i) |=> halt_ff;
  endproperty
  a_reset_halts: assert property (p_reset_halts) else $error("halt not held during reset");

  property p_release;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && release_req) |=> (!halt_ff && !stop_ff);
  endproperty
  a_release: assert property (p_release) else $error("standby not released by flag");

  property p_refuse;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && release_req && !halt_ff && halt_instr_i) |=> !halt_ff;
  endproperty
  a_refuse: assert property (p_refuse) else $error("halt entered with flag set");

  property p_timer_clear;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && timer_instr_i) |=> (count_ff == 8'h00);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer instruction did not clear");

  property p_halt_freezes_cpu;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && halt_ff) ##1 halt_ff |-> !cpu_en_ff;
  endproperty
  a_halt_freezes_cpu: assert property (p_halt_freezes_cpu) else $error("cpu clock ran in halt");

  property p_reset_clears;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && reset_pin_i) |=> (!timer_flag_ff && !shared_flag_ff && !request_source_select_ff);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left flags set");

  property p_pin_edge;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && request_source_select_ff && event_rise) |=> shared_flag_ff;
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("pin edge missed");

  property p_stop_enter;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && stop_instr_i && !release_req && !reset_fall) |=> stop_ff;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop instruction ignored");

  property p_stop_cuts_osc;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && stop_ff && !stop_blocks) |=> !osc_en_ff;
  endproperty
  a_stop_cuts_osc: assert property (p_stop_cuts_osc) else $error("system clock ran in stop");

  property p_halt_enter;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && halt_instr_i && !release_req && !reset_fall) |=> halt_ff;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt instruction ignored");

  property p_reset_fall_wakes;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && reset_fall) |=> (!halt_ff && !stop_ff);
  endproperty
  a_reset_fall_wakes: assert property (p_reset_fall_wakes) else $error("reset fall left standby");

  property p_stop_refuse;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && release_req && stop_instr_i) |=> !stop_ff;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("stop entered with flag set");

  property p_reset_stop;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && reset_pin_i) |=> !stop_ff;
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("reset left stop set");

  property p_ceramic_quiet;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && reset_pin_i && !RC_VARIANT) |=> (!osc_en_ff && !cpu_en_ff);
  endproperty
  a_ceramic_quiet: assert property (p_ceramic_quiet) else $error("clocks ran during reset");

  property p_cpu_divide;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && cpu_en_ff) |=> !cpu_en_ff;
  endproperty
  a_cpu_divide: assert property (p_cpu_divide) else $error("cpu clock not halved");

  property p_shared_serial;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && !request_source_select_ff && serial_done_event_i) |=> shared_flag_ff;
  endproperty
  a_shared_serial: assert property (p_shared_serial) else $error("serial done missed");

  property p_serial_start_clear;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && !request_source_select_ff && serial_start_instruction_i && !shared_set)
        |=> !shared_flag_ff;
  endproperty
  a_serial_start_clear: assert property (p_serial_start_clear) else $error("serial start kept flag");

  property p_pin_holds;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && request_source_select_ff && shared_flag_ff && !test_shared) |=> shared_flag_ff;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("pin flag lost without test");

  property p_test_report;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && test_and_clear_instruction_i) |=> (test_valid_ff && test_result_ff == $past(tested_flag));
  endproperty
  a_test_report: assert property (p_test_report) else $error("test result wrong");

  property p_test_clears_timer;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && test_timer && !wrap) |=> !timer_flag_ff;
  endproperty
  a_test_clears_timer: assert property (p_test_clears_timer) else $error("test left timer flag");

  property p_count_step;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && !timer_instr_i && count_step) |=> (count_ff == $past(count_ff) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter missed a pulse");

  property p_count_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && !timer_instr_i && !count_step) |=> $stable(count_ff);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without pulse");

  property p_event_count;
    @(posedge clock_i) disable iff (!reset_n_i)
      (clock_en_i && !reset_pin_i && !timer_instr_i && sel_event && event_rise) |=> (count_ff == $past(count_ff) + 8'h01);
  endproperty
  a_event_count: assert property (p_event_count) else $error("event edge not counted");

  property p_ce_freeze;
    @(posedge clock_i) disable iff (!reset_n_i)
      !clock_en_i |=> ($stable(count_ff) && $stable(halt_ff) && $stable(stop_ff) && $stable(timer_flag_ff)
        && $stable(shared_flag_ff));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
endmodule : sctc_core

// [core/sctc_pkg.sv]
// constants and types for the standby clock and timer control block
package sctc_pkg;
  localparam int TIMER_WIDTH = 8;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_DIV256 = 2'h0;
  localparam logic [1:0] SEL_EVENT = 2'h1;
  localparam logic [1:0] SEL_DIV32 = 2'h2;
  localparam logic [1:0] SEL_DIV4 = 2'h3;
  localparam int PRESCALE_WIDTH = 8;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] MASK_DIV256 = 8'hFF;
  localparam logic [7:0] MASK_DIV32 = 8'h1F;
  localparam logic [7:0] MASK_DIV4 = 8'h03;
  typedef enum logic [1:0] {
    SCTC_RUN,
    SCTC_HALT,
    SCTC_STOP
  } sctc_mode_type;
endpackage : sctc_pkg

// [core/sctc_prescaler.sv]
// free-running system clock divider producing single-cycle count enables
`timescale 1ns/1ps
module sctc_prescaler #(
  parameter int WIDTH = sctc_pkg::PRESCALE_WIDTH
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] mask_i,
  output logic tick_o
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic tick_ff;
  assign nxt_count = count_ff + WIDTH'(1);
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      count_ff <= sctc_pkg::PRESCALE_RESET;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= run_i && ((count_ff & mask_i) == mask_i);
      if (run_i) begin
        count_ff <= nxt_count;
      end
    end
  end
  assign tick_o = tick_ff;
endmodule : sctc_prescaler

// [testbench/sctc_cpu_model.sv]
// cpu-side model issuing instruction pulses and driving the reset pin
`timescale 1ns/1ps
module sctc_cpu_model #(
  parameter int SETTLE_CYCLES = 16
) (
  input wire logic clock_i,
  output logic [6:0] op_o,
  output logic [1:0] data_o,
  output logic sel_o,
  output logic reset_pin_o
);
  initial begin
    op_o = 7'h00;
    data_o = 2'h0;
    sel_o = 1'b0;
    reset_pin_o = 1'b0;
  end
  // one-cycle pulse; the gap cycle that follows keeps pulses from merging
  task automatic issue(input int idx, input logic [1:0] data, input logic sel);
    @(negedge clock_i);
    op_o[idx] = 1'b1;
    data_o = data;
    sel_o = sel;
    @(negedge clock_i);
    op_o = 7'h00;
  endtask : issue
  // held past the oscillator settling time
  task automatic hold_reset();
    @(negedge clock_i);
    reset_pin_o = 1'b1;
    repeat (SETTLE_CYCLES) @(negedge clock_i);
    reset_pin_o = 1'b0;
  endtask : hold_reset
endmodule : sctc_cpu_model

// [testbench/standby_clock_timer_control_tb_top.sv]
// self-checking testbench for the standby clock and timer control block
`timescale 1ns/1ps
module standby_clock_timer_control_tb_top;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [6:0] op;
  logic [1:0] pdata;
  logic sel, rpin, osc_en, cpu_en, stop_m, halt_m, tovf, shflag, tres, tval, srcsel;
  logic sdone = 1'b0;
  logic evpin = 1'b0;
  logic ce = 1'b1;
  logic [7:0] cnt, c, n;
  logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
  int per [3] = '{256, 32, 4};
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  initial forever #2.5 clock_i = ~clock_i;

  sctc_cpu_model u_cpu (.clock_i(clock_i), .op_o(op), .data_o(pdata), .sel_o(sel), .reset_pin_o(rpin));

  sctc_core u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .clock_en_i(ce), .reset_pin_i(rpin),
    .osc_input_pin_i(1'b0), .stop_instr_i(op[0]), .halt_instr_i(op[1]), .timer_instr_i(op[2]),
    .port_output_instruction_i(op[3]), .port_data_i(pdata), .test_and_clear_instruction_i(op[4]),
    .test_select_i(sel), .serial_start_instruction_i(op[5]), .serial_done_event_i(sdone),
    .request_source_write_i(op[6]), .request_source_data_i(sel), .event_pin_i(evpin),
    .osc_clock_en_o(osc_en), .cpu_clock_en_o(cpu_en), .stop_mode_o(stop_m), .halt_mode_o(halt_m),
    .timer_count_o(cnt), .timer_overflow_request_o(tovf), .shared_request_flag_o(shflag),
    .test_result_o(tres), .test_valid_o(tval), .request_source_select_o(srcsel)
  );

  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_n(input int k);
    repeat (k) @(negedge clock_i);
  endtask : wait_n

  // counts cpu clock enables; an unknown poisons the sum
  task automatic count_cpu(input int k);
    n = 8'h00;
    repeat (k) begin
      @(negedge clock_i);
      n = n + {7'h00, cpu_en};
    end
  endtask : count_cpu

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    wait_n(12);
    reset_n_i = 1'b1;
    wait_n(1);
    check({tovf, shflag, srcsel, stop_m, halt_m}, 8'h00);
    count_cpu(8);
    check(n, 8'h04);
    for (int i = 0; i < 3; i++) begin
      u_cpu.issue(3, codes[i], 1'b0);
      c = cnt;
      for (int k = 0; k < 300 && cnt === c; k++) @(negedge clock_i);
      c = cnt;
      wait_n(2 * per[i]);
      check(cnt, c + 8'h02);
    end
    u_cpu.issue(2, 2'h0, 1'b0);
    check({cnt, tovf}, 9'h000);
    ce = 1'b0;
    c = cnt;
    wait_n(20);
    check(cnt, c);
    ce = 1'b1;
    wait_n(1000);
    check(tovf, 1'b0);
    wait_n(40);
    check(tovf, 1'b1);
    check(cnt[7:4], 4'h0);
    u_cpu.issue(1, 2'h0, 1'b0);
    check(halt_m, 1'b0);
    u_cpu.issue(4, 2'h0, 1'b0);
    check({tval, tres, tovf}, 8'h06);
    u_cpu.issue(1, 2'h0, 1'b0);
    check(halt_m, 1'b1);
    count_cpu(6);
    check({n, osc_en}, 9'h001);
    sdone = 1'b1;
    wait_n(1);
    sdone = 1'b0;
    wait_n(1);
    check(shflag, 1'b1);
    wait_n(1);
    check(halt_m, 1'b0);
    u_cpu.issue(5, 2'h0, 1'b0);
    check(shflag, 1'b0);
    u_cpu.issue(6, 2'h0, 1'b1);
    check(srcsel, 1'b1);
    u_cpu.issue(0, 2'h0, 1'b0);
    check(stop_m, 1'b1);
    wait_n(2);
    check(osc_en, 1'b0);
    evpin = 1'b1;
    wait_n(6);
    check({shflag, stop_m}, 8'h02);
    evpin = 1'b0;
    u_cpu.issue(5, 2'h0, 1'b0);
    check(shflag, 1'b1);
    u_cpu.issue(4, 2'h0, 1'b1);
    check({tres, shflag}, 8'h02);
    u_cpu.issue(3, 2'h1, 1'b0);
    u_cpu.issue(2, 2'h0, 1'b0);
    repeat (3) begin
      evpin = 1'b1;
      wait_n(4);
      evpin = 1'b0;
      wait_n(4);
    end
    wait_n(6);
    check(cnt, 8'h03);
    u_cpu.hold_reset();
    check(halt_m, 1'b1);
    check({cnt, tovf, shflag, srcsel}, 11'h000);
    wait_n(2);
    check(halt_m, 1'b0);
    summarize();
  end
endmodule : standby_clock_timer_control_tb_top
